// >>> pkg/scss_regs.svh
// Register offsets, field positions, reset values and switch counts
// Assumes 32-bit APB data with the control register in the low byte
`ifndef SCSS_REGS_SVH
`define SCSS_REGS_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define SCSS_OSC_CTRL_ADDR 12'h000

// -----------------------------------------------------------------
// Oscillator control fields
// -----------------------------------------------------------------
`define SCSS_IDLE_BIT 7
`define SCSS_FREQ_MSB 6
`define SCSS_FREQ_LSB 4
`define SCSS_DONE_BIT 3
`define SCSS_STABLE_BIT 2
`define SCSS_SEL_MSB 1
`define SCSS_SEL_LSB 0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define SCSS_IDLE_RST 1'h0
`define SCSS_FREQ_RST 3'h4
`define SCSS_SEL_RST 2'h0
`define SCSS_STABLE_RST 1'h0

// -----------------------------------------------------------------
// Source switch pause, in source cycles
// -----------------------------------------------------------------
`define SCSS_OLD_EDGES 2'h2
`define SCSS_NEW_EDGES 2'h3

`endif

// >>> pkg/scss_pkg.sv
// Types of the system clock source selector
// Assumes nothing of its surroundings
`default_nettype none

package scss_pkg;

   // -----------------------------------------------------------------
   // Clock sources, switch states, power-managed modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10
   } scss_src_e;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_OLD   = 2'b01,
      ST_NEW   = 2'b10,
      ST_SLEEP = 2'b11
   } scss_state_e;

   typedef enum logic [2:0] {
      PM_PRI_RUN  = 3'b000,
      PM_SECONDARY_RUN_MODE  = 3'b001,
      PM_INT_RUN  = 3'b010,
      PM_PRIMARY_IDLE_MODE = 3'b100,
      PM_SECONDARY_IDLE_MODE = 3'b101,
      PM_INT_IDLE = 3'b110,
      PM_SLEEP    = 3'b111
   } scss_mode_e;

endpackage

`default_nettype wire

// >>> hdl/scss_selector.sv
// System clock source selector: control register, glitch-free switch,
// internal postscaler, status bits and oscillator gating.
// Assumes oscillator waveforms arrive as asynchronous pins, slower than
// a quarter of core_clk_i, and an APB master on core_clk_i.
//
// How it works
// - Select 00 primary, 01 secondary, 1x internal
// - Reset clears the source select field
// - Select write starts switch to new source
// - Frequency field sets postscaler divide ratio
// - Frequency change acts on postscaler at once
// - Reset returns frequency field to 1 MHz
// - 31 kHz from fast/256 or slow oscillator
// - Watchdog clock always from slow oscillator
// - Startup-done bit follows timer and primary
// - Stable bit follows settled fast internal clock
// - Secondary active while timer oscillator clocks
// - At most one status bit set
// - Sleep instruction enters idle or sleep
// - Secondary select ignored without oscillator enable
// - Pause two old, three new cycles
// - Primary runs only in primary modes or while switching to primary
// - Timer oscillator may run in all modes
// - Fast oscillator off when slow clocks directly
// - Sleep stops all sources except needed ones
// - Register reset values, startup bit from strap
// - Mode formed from idle flag latched at sleep and active source
`default_nettype none

`include "scss_regs.svh"

module scss_selector #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Oscillator pins and their status
   input wire logic pri_osc_i,
   input wire logic sec_osc_i,
   input wire logic fast_osc_i,
   input wire logic slow_osc_i,
   input wire logic ost_expired_i,
   input wire logic fast_settled_i,
   // Configuration and neighbour controls
   input wire logic internal_external_switchover_i,
   input wire logic low_freq_source_select_i,
   input wire logic secondary_osc_enable_i,
   input wire logic secondary_timer_need_i,
   input wire logic wdt_enable_i,
   input wire logic fscm_enable_i,
   // Processor
   input wire logic sleep_exec_i,
   input wire logic wake_i,
   // Clock enables out
   output logic cpu_tick_o,
   output logic periph_tick_o,
   output logic wdt_tick_o,
   // Oscillator gating
   output logic pri_osc_en_o,
   output logic sec_osc_en_o,
   output logic fast_osc_en_o,
   output logic slow_osc_en_o,
   // Status
   output logic secondary_clock_active_o,
   output logic switching_o,
   output logic [1:0] active_src_o,
   output logic [2:0] power_mode_o
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [5:0] raw;
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic [5:0] sync3;
   logic [5:0] filt;
   logic [5:0] rise;
   wire [5:0] agree = sync2 ~^ sync3;

   assign raw = {fast_settled_i, ost_expired_i, slow_osc_i, fast_osc_i, sec_osc_i, pri_osc_i};

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
         filt <= 6'h00;
         rise <= 6'h00;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         filt <= (agree & sync3) | (~agree & filt);
         rise <= agree & sync3 & ~filt;
      end
   end

   wire pri_rise = rise[0];
   wire sec_rise = rise[1];
   wire fast_rise = rise[2];
   wire slow_rise = rise[3];
   wire ost_done = filt[4];
   wire fast_settled = filt[5];

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   logic idle_sel;
   logic [2:0] freq_sel;
   logic [1:0] sel;
   logic startup_done;
   logic fast_stable;

   wire addr_hit = paddr_i == `SCSS_OSC_CTRL_ADDR;
   wire access = psel_i & penable_i;
   wire wr_en = access & pwrite_i & addr_hit;
   wire [1:0] wr_sel = pwdata_i[`SCSS_SEL_MSB:`SCSS_SEL_LSB];
   wire sel_refused = (wr_sel == 2'b01) & ~secondary_osc_enable_i;
   wire [7:0] rd_val = {idle_sel, freq_sel, startup_done, fast_stable, sel};

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         idle_sel <= `SCSS_IDLE_RST;
         freq_sel <= `SCSS_FREQ_RST;
         sel <= `SCSS_SEL_RST;
      end else if (wr_en) begin
         idle_sel <= pwdata_i[`SCSS_IDLE_BIT];
         freq_sel <= pwdata_i[`SCSS_FREQ_MSB:`SCSS_FREQ_LSB];
         if (!sel_refused) begin
            sel <= wr_sel;
         end
      end
   end

   assign pready_o = 1'b1;
   assign pslverr_o = access & ~addr_hit;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i & ~penable_i) begin
         prdata_o <= addr_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Internal oscillator postscaler
   // -----------------------------------------------------------------
   logic [7:0] div_cnt;
   logic [7:0] div_last;
   logic fast_div_tick;

   always_comb begin
      case (freq_sel)
         3'h7: div_last = 8'h00;
         3'h6: div_last = 8'h01;
         3'h5: div_last = 8'h03;
         3'h4: div_last = 8'h07;
         3'h3: div_last = 8'h0F;
         3'h2: div_last = 8'h1F;
         3'h1: div_last = 8'h3F;
         default: div_last = 8'hFF;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         div_cnt <= 8'h00;
         fast_div_tick <= 1'b0;
      end else begin
         fast_div_tick <= fast_rise & (div_cnt >= div_last);
         if (fast_rise) begin
            div_cnt <= (div_cnt >= div_last) ? 8'h00 : div_cnt + 8'h01;
         end
      end
   end

   wire fast_used = (freq_sel != 3'h0) | low_freq_source_select_i;
   wire int_tick = fast_used ? fast_div_tick : slow_rise;

   // -----------------------------------------------------------------
   // Source switch sequencer
   // -----------------------------------------------------------------
   scss_pkg::scss_state_e state;
   scss_pkg::scss_src_e active;
   scss_pkg::scss_src_e pend;
   scss_pkg::scss_src_e target;
   logic [1:0] edge_cnt;
   logic idle_q;
   logic act_tick;

   assign target = sel[1] ? scss_pkg::SRC_INT :
                   (sel[0] ? scss_pkg::SRC_SEC : scss_pkg::SRC_PRI);

   always_comb begin
      case (active)
         scss_pkg::SRC_PRI: act_tick = pri_rise;
         scss_pkg::SRC_SEC: act_tick = sec_rise;
         default: act_tick = int_tick;
      endcase
   end

   wire [1:0] cnt_inc = edge_cnt + 2'h1;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state <= scss_pkg::ST_RUN;
         active <= scss_pkg::SRC_PRI;
         pend <= scss_pkg::SRC_PRI;
         edge_cnt <= 2'h0;
         idle_q <= 1'b0;
      end else begin
         case (state)
            scss_pkg::ST_RUN: begin
               if (sleep_exec_i && !idle_sel) begin
                  state <= scss_pkg::ST_SLEEP;
               end else if (target != active) begin
                  pend <= target;
                  edge_cnt <= 2'h0;
                  state <= scss_pkg::ST_OLD;
               end
               if (sleep_exec_i && idle_sel) begin
                  idle_q <= 1'b1;
               end else if (wake_i) begin
                  idle_q <= 1'b0;
               end
            end
            scss_pkg::ST_OLD: begin
               if (act_tick) begin
                  edge_cnt <= cnt_inc;
                  if (cnt_inc == `SCSS_OLD_EDGES) begin
                     edge_cnt <= 2'h0;
                     active <= pend;
                     state <= scss_pkg::ST_NEW;
                  end
               end
            end
            scss_pkg::ST_NEW: begin
               if (act_tick) begin
                  edge_cnt <= cnt_inc;
                  if (cnt_inc == `SCSS_NEW_EDGES) begin
                     edge_cnt <= 2'h0;
                     state <= scss_pkg::ST_RUN;
                  end
               end
            end
            scss_pkg::ST_SLEEP: begin
               if (wake_i) begin
                  state <= scss_pkg::ST_RUN;
               end
            end
            default: state <= scss_pkg::ST_RUN;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Clock enables, status and gating
   // -----------------------------------------------------------------
   wire running = state == scss_pkg::ST_RUN;
   wire asleep = state == scss_pkg::ST_SLEEP;
   wire to_pend = state == scss_pkg::ST_OLD;
   wire uses_pri = (active == scss_pkg::SRC_PRI) | (to_pend & (pend == scss_pkg::SRC_PRI));
   wire uses_int = (active == scss_pkg::SRC_INT) | (to_pend & (pend == scss_pkg::SRC_INT));
   wire next_startup_done = ost_done & running & (active == scss_pkg::SRC_PRI);
   wire next_fast_stable = fast_settled & running & fast_used & (active == scss_pkg::SRC_INT);
   wire next_sec_act = running & (active == scss_pkg::SRC_SEC);
   wire [2:0] next_mode = asleep ? scss_pkg::PM_SLEEP : {idle_q, active};

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         startup_done <= internal_external_switchover_i;
         fast_stable <= `SCSS_STABLE_RST;
         secondary_clock_active_o <= 1'b0;
         cpu_tick_o <= 1'b0;
         periph_tick_o <= 1'b0;
         wdt_tick_o <= 1'b0;
         pri_osc_en_o <= 1'b1;
         sec_osc_en_o <= 1'b0;
         fast_osc_en_o <= 1'b0;
         slow_osc_en_o <= 1'b0;
         switching_o <= 1'b0;
         active_src_o <= 2'h0;
         power_mode_o <= 3'h0;
      end else begin
         startup_done <= next_startup_done;
         fast_stable <= next_fast_stable;
         secondary_clock_active_o <= next_sec_act;
         cpu_tick_o <= running & ~idle_q & act_tick;
         periph_tick_o <= running & act_tick;
         wdt_tick_o <= slow_rise;
         pri_osc_en_o <= ~asleep & uses_pri;
         sec_osc_en_o <= secondary_osc_enable_i & (~asleep | secondary_timer_need_i);
         fast_osc_en_o <= ~asleep & uses_int & fast_used;
         slow_osc_en_o <= wdt_enable_i | fscm_enable_i | (~asleep & uses_int & ~fast_used);
         switching_o <= ~running & ~asleep;
         active_src_o <= active;
         power_mode_o <= next_mode;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   property p_switch_start;
      running && !sleep_exec_i && (target != active) |=>
         (state == scss_pkg::ST_OLD) && (pend == $past(target));
   endproperty
   a_switch_start: assert property (p_switch_start)
      else $error("switch did not start on select change");

   property p_reset_vals;
      $past(srst_i) |-> (sel == 2'h0) && (freq_sel == 3'h4) && !idle_sel && !fast_stable
         && (startup_done == $past(internal_external_switchover_i));
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("wrong register value after reset");

   property p_sec_refused;
      wr_en && (wr_sel == 2'b01) && !secondary_osc_enable_i |=> sel == $past(sel);
   endproperty
   a_sec_refused: assert property (p_sec_refused)
      else $error("secondary select taken without oscillator enable");

   property p_old_edges;
      to_pend && (edge_cnt == 2'h1) && act_tick |=>
         (state == scss_pkg::ST_NEW) && (active == $past(pend));
   endproperty
   a_old_edges: assert property (p_old_edges)
      else $error("old source pause not two cycles");

   property p_new_edges;
      (state == scss_pkg::ST_NEW) && (edge_cnt == 2'h2) && act_tick |=> running;
   endproperty
   a_new_edges: assert property (p_new_edges)
      else $error("new source pause not three cycles");

   property p_sleep_entry;
      running && sleep_exec_i && !idle_sel |=> asleep ##1 (power_mode_o == 3'h7);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep not entered");

   property p_onehot_status;
      $onehot0({startup_done, fast_stable, secondary_clock_active_o});
   endproperty
   a_onehot_status: assert property (p_onehot_status)
      else $error("more than one source status bit set");

   property p_pri_off;
      asleep && $past(asleep) |-> !pri_osc_en_o && !fast_osc_en_o;
   endproperty
   a_pri_off: assert property (p_pri_off)
      else $error("oscillator left running in sleep");

   property p_fast_off;
      running && !fast_used && (active == scss_pkg::SRC_INT) && $stable(freq_sel)
         && $stable(low_freq_source_select_i) |=> !fast_osc_en_o;
   endproperty
   a_fast_off: assert property (p_fast_off)
      else $error("fast oscillator on while slow clocks directly");

   property p_wdt_src;
      wdt_tick_o == $past(slow_rise);
   endproperty
   a_wdt_src: assert property (p_wdt_src)
      else $error("watchdog tick not from slow oscillator");

   property p_slow_direct;
      running && !idle_q && (active == scss_pkg::SRC_INT) && !fast_used |=>
         cpu_tick_o == $past(slow_rise);
   endproperty
   a_slow_direct: assert property (p_slow_direct)
      else $error("31 kHz source wrong");

endmodule

`default_nettype wire

// >>> test/scss_osc_model.sv
// Behavioural oscillators and their start-up status for the selector
// Assumes enables come from the selector; a disabled oscillator holds low
`default_nettype none

// -----------------------------------------------------------------
// Oscillator sources
// -----------------------------------------------------------------
module scss_osc_model (
   // Enables
   input wire logic pri_en_i,
   input wire logic sec_en_i,
   input wire logic fast_en_i,
   input wire logic slow_en_i,
   // Waveforms and status
   output logic pri_osc_o,
   output logic sec_osc_o,
   output logic fast_osc_o,
   output logic slow_osc_o,
   output logic startup_expired_o,
   output logic fast_settled_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pri_osc_o = 1'b0;
      forever begin
         #500;
         pri_osc_o = pri_en_i ? ~pri_osc_o : 1'b0;
      end
   end

   initial begin
      sec_osc_o = 1'b0;
      forever begin
         #1500;
         sec_osc_o = sec_en_i ? ~sec_osc_o : 1'b0;
      end
   end

   initial begin
      fast_osc_o = 1'b0;
      forever begin
         #400;
         fast_osc_o = fast_en_i ? ~fast_osc_o : 1'b0;
      end
   end

   initial begin
      slow_osc_o = 1'b0;
      forever begin
         #800;
         slow_osc_o = slow_en_i ? ~slow_osc_o : 1'b0;
      end
   end

   // start-up expires a while after enable
   initial begin
      startup_expired_o = 1'b0;
      forever begin
         wait (pri_en_i);
         #2000;
         startup_expired_o = pri_en_i;
         wait (!pri_en_i);
         startup_expired_o = 1'b0;
      end
   end

   initial begin
      fast_settled_o = 1'b0;
      forever begin
         wait (fast_en_i);
         #1000;
         fast_settled_o = fast_en_i;
         wait (!fast_en_i);
         fast_settled_o = 1'b0;
      end
   end
endmodule

`default_nettype wire

// >>> test/scss_selector_bench.sv
// Self-checking bench for the clock source selector over APB
// Assumes the oscillator model drives the pins; 10 MHz core clock
`default_nettype none

module system_clock_source_selector_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pri, sec, fast, slow, st_ok, settled, strap, lowf, sec_en, tneed, wdt_en, slp, wake;
   logic fscm_en;
   logic cpu_t, per_t, wdt_t, pri_en, sec_on, fast_en, slow_en, sca, sw;
   logic [1:0] asrc;
   logic [2:0] pm;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int c_cpu, c_per, c_wdt;

   scss_selector uut (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pri_osc_i(pri), .sec_osc_i(sec),
      .fast_osc_i(fast), .slow_osc_i(slow), .ost_expired_i(st_ok), .fast_settled_i(settled),
      .internal_external_switchover_i(strap), .low_freq_source_select_i(lowf),
      .secondary_osc_enable_i(sec_en), .secondary_timer_need_i(tneed),
      .wdt_enable_i(wdt_en), .fscm_enable_i(fscm_en), .sleep_exec_i(slp), .wake_i(wake),
      .cpu_tick_o(cpu_t), .periph_tick_o(per_t), .wdt_tick_o(wdt_t), .pri_osc_en_o(pri_en),
      .sec_osc_en_o(sec_on), .fast_osc_en_o(fast_en), .slow_osc_en_o(slow_en),
      .secondary_clock_active_o(sca), .switching_o(sw), .active_src_o(asrc),
      .power_mode_o(pm));

   scss_osc_model osc (.pri_en_i(pri_en), .sec_en_i(sec_on), .fast_en_i(fast_en),
      .slow_en_i(slow_en), .pri_osc_o(pri), .sec_osc_o(sec), .fast_osc_o(fast),
      .slow_osc_o(slow), .startup_expired_o(st_ok), .fast_settled_o(settled));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic near(input int got, input int exp);
      check((got >= exp - 1 && got <= exp + 1) ? exp : got, exp);
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] exp);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, exp);
   endtask

   task automatic wait_sw;
      logic saw;
      saw = 1'b0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         if (sw === 1'b1) saw = 1'b1;
         else if (saw) break;
      end
      check(32'(saw), 32'h1);
   endtask

   task automatic count(input int w);
      c_cpu = 0;
      c_per = 0;
      c_wdt = 0;
      repeat (w) begin
         @(posedge clk);
         c_cpu += int'(cpu_t === 1'b1);
         c_per += int'(per_t === 1'b1);
         c_wdt += int'(wdt_t === 1'b1);
      end
   endtask

   task automatic pulse(input logic do_wake);
      @(posedge clk);
      if (do_wake) wake <= 1'b1;
      else slp <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      slp <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // -----------------------------------------------------------------
   // Clock and timeout
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         tally_and_finish;
      end
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, strap, lowf, sec_en, tneed, slp, wake, fscm_en} = 10'h000;
      wdt_en = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (60) @(posedge clk);
      check(32'(pm), 32'h0);
      check(32'(asrc), 32'h0);
      rdchk(32'h48);
      apb(1'b1, 12'h000, 32'h4C);
      rdchk(32'h48);
      apb(1'b0, 12'h004, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      check(32'(pready), 32'h1);
      apb(1'b1, 12'h000, 32'h41);
      repeat (10) @(posedge clk);
      rdchk(32'h48);
      apb(1'b1, 12'h000, 32'h72);
      wait_sw;
      check(32'(asrc), 32'h2);
      check(32'(pm), 32'h2);
      check(32'(pri_en), 32'h0);
      repeat (30) @(posedge clk);
      rdchk(32'h76);
      for (int c = 7; c >= 1; c--) begin
         apb(1'b1, 12'h000, {25'h0, 3'(c), 4'h3});
         count(4096);
         near(c_cpu, 512 >> (7 - c));
         near(c_wdt, 256);
         check(32'(asrc), 32'h2);
      end
      lowf <= 1'b1;
      apb(1'b1, 12'h000, 32'h02);
      count(4096);
      near(c_cpu, 2);
      check(32'(fast_en), 32'h1);
      lowf <= 1'b0;
      count(4096);
      near(c_cpu, 256);
      near(c_wdt, 256);
      check(32'(fast_en), 32'h0);
      rdchk(32'h02);
      // Timer oscillator started well before it is selected
      sec_en <= 1'b1;
      tneed <= 1'b1;
      repeat (100) @(posedge clk);
      apb(1'b1, 12'h000, 32'h41);
      wait_sw;
      check(32'(sca), 32'h1);
      check(32'(asrc), 32'h1);
      rdchk(32'h41);
      apb(1'b1, 12'h000, 32'hC1);
      pulse(1'b0);
      check(32'(pm), 32'h5);
      count(400);
      check(32'(c_cpu), 32'h0);
      check(32'(c_per > 0), 32'h1);
      check(32'(sec_on), 32'h1);
      pulse(1'b1);
      check(32'(pm), 32'h1);
      apb(1'b1, 12'h000, 32'hC0);
      wait_sw;
      check(32'(asrc), 32'h0);
      check(32'(sca), 32'h0);
      pulse(1'b0);
      check(32'(pm), 32'h4);
      check(32'(pri_en), 32'h1);
      pulse(1'b1);
      apb(1'b1, 12'h000, 32'h40);
      pulse(1'b0);
      check(32'(pm), 32'h7);
      check({28'h0, pri_en, fast_en, sec_on, slow_en}, 32'h3);
      count(200);
      check(32'(c_per), 32'h0);
      wdt_en <= 1'b0;
      fscm_en <= 1'b1;
      repeat (3) @(posedge clk);
      check(32'(slow_en), 32'h1);
      fscm_en <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(slow_en), 32'h0);
      wdt_en <= 1'b1;
      pulse(1'b1);
      check(32'(pm), 32'h0);
      // Mid-run reset from a non-default setting
      apb(1'b1, 12'h000, 32'hF2);
      strap <= 1'b1;
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      strap <= 1'b0;
      repeat (60) @(posedge clk);
      check(32'(asrc), 32'h0);
      check(32'(pm), 32'h0);
      rdchk(32'h48);
      tally_and_finish;
   end
endmodule

`default_nettype wire
